// ---- src/aopv_pkg.sv ----
// package for the audio output power and volume control block
package aopv_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [11:0] OFS_OUTPUT_POWER_CONTROL = 12'h800;
   localparam logic [11:0] OFS_HEADPHONE_SETTINGS = 12'h802;
   localparam logic [11:0] OFS_OUTPUT_AMP_POWERUP_TIME = 12'h804;
   localparam logic [11:0] OFS_CONVERTER_VOLUME = 12'h806;
   localparam logic [11:0] OFS_CONVERTER_BALANCE = 12'h808;
   localparam logic [11:0] OFS_CONVERTER_CHANNEL_MUTE = 12'h80a;
   localparam logic [11:0] OFS_VOLUME_RAMP_RATE = 12'h80c;
   localparam logic [11:0] OFS_OUTPUT_SETTLE_STATUS = 12'h80e;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h902;
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h90c;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int BIT_LINE_AMP = 0;
   localparam int BIT_HEADPHONE_AMP = 1;
   localparam int BIT_CONVERTER = 2;
   localparam int BIT_COMMON_PIN = 0;
   localparam int BIT_HP_RESERVED = 1;
   localparam int BIT_HP_TIME_LO = 2;
   localparam int BIT_LINE_SETTLED = 0;
   localparam int BIT_HP_SETTLED = 1;
   localparam int BIT_VOL_REACHED = 2;
   localparam int BIT_OUTPUT_READY = 3;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RST_OUTPUT_POWER_CONTROL = 8'h00;
   localparam logic [7:0] RST_HEADPHONE_SETTINGS = 8'h06;
   localparam logic [7:0] RST_OUTPUT_AMP_POWERUP_TIME = 8'h00;
   localparam logic [6:0] RST_CONVERTER_VOLUME = 7'h00;
   localparam logic [7:0] RST_CONVERTER_BALANCE = 8'h00;
   localparam logic [1:0] RST_CHANNEL_MUTE = 2'h3;
   localparam logic [1:0] RST_VOLUME_RAMP_STEP = 2'h1;

   // ----------------------------------------
   // level codes and timing
   // ----------------------------------------
   localparam logic [6:0] VOL_MAX_AUDIBLE = 7'h48;
   localparam logic [3:0] BAL_MUTE = 4'hf;
   localparam logic [7:0] ATT_MUTE = 8'hff;
   localparam int HP_TIME_44K_MS = 23;
   localparam int HP_TIME_48K_MS = 21;
   localparam int HP_TIME_32K_MS = 32;
   localparam int LINE_UNIT_MS = 10;
   localparam int RAMP_SAMPLES_0 = 128;
   localparam int RAMP_SAMPLES_1 = 32;
   localparam int RAMP_SAMPLES_2 = 8;
   localparam int RAMP_SAMPLES_3 = 1;

   typedef enum logic [1:0] {AOPV_FAM_44K, AOPV_FAM_48K, AOPV_FAM_32K} aopv_rate_family_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } aopv_bus_req_t;

   typedef struct packed {
      logic line_amp_enable;
      logic headphone_amp_enable;
      logic converter_enable;
   } aopv_power_t;
endpackage

// ---- src/aopv_ctrl.sv ----
// audio output power sequencing, volume ramping and settle status
`timescale 1ns/10ps
// Summary of operation
// [RQ1] bit 0 of output control powers the line amplifier; resets off
// [RQ2] bit 1 of output control powers the headphone amplifier; resets off
// [RQ3] bit 2 of output control enables the audio converter; resets off
// [RQ4] software writes headphone settings only with converter and headphone amp off
// [RQ5] common pin bit 0: high impedance when 0, drives signal ground when 1
// [RQ6] software writes 0 to reserved headphone bit 1, which resets to 1
// [RQ7] headphone transition 23/21/32 ms per rate family, doubled code 1, quadrupled code 2
// [RQ8] line amplifier power-up time is the setting times 10 ms
// [RQ9] software changes line power-up setting only with line amplifier off
// [RQ10] volume 1 dB steps, 0x00 is 0 dB, 0x48 is -72 dB, above mutes
// [RQ11] balance 4-bit per channel, 2 dB steps to -28 dB, 0x0f mutes
// [RQ12] mute code: 0 none, 1 left, 2 right, 3 both; resets to 3
// [RQ13] level ramps 1 dB per step every 128, 32, 8 or 1 samples
// [RQ14] software changes ramp rate only with converter and headphone amp off
// [RQ15] line settled flag sets when line amplifier active and stable; write 1 clears
// [RQ16] headphone settled flag sets when headphone amp stable on or off; write 1 clears
// [RQ17] volume reached flag sets when a ramp reaches its target; write 1 clears
// [RQ18] no volume reached flag when the effective level does not change
// [RQ19] any status flag becoming set raises the output ready status
// [RQ20] output ready status reads 1 while any output status flag is 1
// [RQ21] output ready interrupt drives the interrupt output only when enabled; enable resets 0
// [RQ22] reset clears all status flags and abandons any ramp at reset volume
module aopv_ctrl #(
   parameter int CLK_HZ = 25000000,
   parameter int SAMPLE_RATE_HZ = 48000,
   parameter int SAMPLE_DIV = CLK_HZ / SAMPLE_RATE_HZ,
   parameter int MS_CYCLES = CLK_HZ / 1000
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire aopv_pkg::aopv_bus_req_t bus_i,
   input wire aopv_pkg::aopv_rate_family_t rate_family_i,
   output aopv_pkg::aopv_power_t power_o,
   output logic common_pin_o,
   output logic common_pin_oe_o,
   output logic [7:0] left_atten_o,
   output logic [7:0] right_atten_o,
   output logic sample_tick_o,
   output logic irq_o,
   output logic [7:0] rdata_o
);
   import aopv_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [2:0] power_ctrl_q;
   logic [7:0] hp_set_q;
   logic [7:0] line_units_q;
   logic [6:0] vol_code_q;
   logic [7:0] bal_q;
   logic [1:0] mute_code_q;
   logic [1:0] ramp_step_q;
   logic [2:0] settle_q;
   logic irq_enable_q;
   logic wr_ctl, wr_hp, wr_line, wr_vol, wr_bal, wr_mute, wr_ramp, wr_stat, wr_ien;

   assign wr_ctl = bus_i.wr && bus_i.addr == OFS_OUTPUT_POWER_CONTROL;
   assign wr_hp = bus_i.wr && bus_i.addr == OFS_HEADPHONE_SETTINGS;
   assign wr_line = bus_i.wr && bus_i.addr == OFS_OUTPUT_AMP_POWERUP_TIME;
   assign wr_vol = bus_i.wr && bus_i.addr == OFS_CONVERTER_VOLUME;
   assign wr_bal = bus_i.wr && bus_i.addr == OFS_CONVERTER_BALANCE;
   assign wr_mute = bus_i.wr && bus_i.addr == OFS_CONVERTER_CHANNEL_MUTE;
   assign wr_ramp = bus_i.wr && bus_i.addr == OFS_VOLUME_RAMP_RATE;
   assign wr_stat = bus_i.wr && bus_i.addr == OFS_OUTPUT_SETTLE_STATUS;
   assign wr_ien = bus_i.wr && bus_i.addr == OFS_IRQ_ENABLE;

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         power_ctrl_q <= RST_OUTPUT_POWER_CONTROL[2:0];
      else if (wr_ctl)
         power_ctrl_q <= bus_i.wdata[2:0]; // RQ1 RQ2 RQ3
   end

   // settings are taken as written; software keeps the power-down order
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         hp_set_q <= RST_HEADPHONE_SETTINGS;
         line_units_q <= RST_OUTPUT_AMP_POWERUP_TIME;
         vol_code_q <= RST_CONVERTER_VOLUME;
         bal_q <= RST_CONVERTER_BALANCE;
         mute_code_q <= RST_CHANNEL_MUTE; // RQ12
         ramp_step_q <= RST_VOLUME_RAMP_STEP;
         irq_enable_q <= 1'b0; // RQ21
      end
      else
      begin
         if (wr_hp)
            hp_set_q <= {4'h0, bus_i.wdata[3:0]}; // RQ4 RQ6
         if (wr_line)
            line_units_q <= bus_i.wdata; // RQ9
         if (wr_vol)
            vol_code_q <= bus_i.wdata[6:0];
         if (wr_bal)
            bal_q <= bus_i.wdata;
         if (wr_mute)
            mute_code_q <= bus_i.wdata[1:0];
         if (wr_ramp)
            ramp_step_q <= bus_i.wdata[1:0]; // RQ14
         if (wr_ien)
            irq_enable_q <= bus_i.wdata[BIT_OUTPUT_READY];
      end
   end

   // ----------------------------------------
   // sample tick
   // ----------------------------------------
   logic [15:0] samp_cnt_q;
   logic tick;
   assign tick = samp_cnt_q == 16'(SAMPLE_DIV - 1);

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         samp_cnt_q <= 16'h0000;
      else
         samp_cnt_q <= tick ? 16'h0000 : samp_cnt_q + 16'h0001;
   end

   // ----------------------------------------
   // power timers
   // ----------------------------------------
   logic [31:0] ms_cnt_q;
   logic ms_tick;
   logic [11:0] line_ms_q;
   logic [7:0] hp_ms_q;
   logic line_on_q, hp_state_q;
   logic line_done, hp_done;
   logic [7:0] hp_target;
   logic [1:0] hp_code;
   assign ms_tick = ms_cnt_q == 32'(MS_CYCLES - 1);
   assign hp_code = hp_set_q[BIT_HP_TIME_LO +: 2];

   always_comb
   begin
      unique case (rate_family_i)
         AOPV_FAM_44K: hp_target = 8'(HP_TIME_44K_MS);
         AOPV_FAM_48K: hp_target = 8'(HP_TIME_48K_MS);
         default: hp_target = 8'(HP_TIME_32K_MS);
      endcase
      // forbidden code 3 held at the x4 time so the 8-bit target never wraps
      hp_target = hp_target << (hp_code == 2'h3 ? 2'h2 : hp_code); // RQ7
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         ms_cnt_q <= 32'h0000_0000;
      else
         ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
   end

   // line amp: counts up while powered until settled, settled once time reached, then holds
   assign line_done = power_ctrl_q[BIT_LINE_AMP] && !line_on_q &&
                      line_ms_q >= 12'(line_units_q) * 12'(LINE_UNIT_MS); // RQ8
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i || !power_ctrl_q[BIT_LINE_AMP])
      begin
         line_ms_q <= 12'h000;
         line_on_q <= 1'b0;
      end
      else
      begin
         if (ms_tick && !line_on_q)
            line_ms_q <= line_ms_q + 12'h001;
         if (line_done)
            line_on_q <= 1'b1;
      end
   end

   // headphone: any change of requested state restarts the transition timer
   assign hp_done = hp_state_q != power_ctrl_q[BIT_HEADPHONE_AMP] && hp_ms_q >= hp_target;
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         hp_ms_q <= 8'h00;
         hp_state_q <= 1'b0;
      end
      else if (hp_state_q == power_ctrl_q[BIT_HEADPHONE_AMP] || hp_done)
      begin
         hp_ms_q <= 8'h00;
         if (hp_done)
            hp_state_q <= power_ctrl_q[BIT_HEADPHONE_AMP];
      end
      else if (ms_tick && hp_ms_q != 8'hff)
         hp_ms_q <= hp_ms_q + 8'h01;
   end

   // ----------------------------------------
   // volume ramp
   // ----------------------------------------
   logic [7:0] tgt_l, tgt_r, cur_l_q, cur_r_q;
   logic [7:0] step_cnt_q, step_len;
   logic step, ramping_q, reached;

   function automatic logic [7:0] level(input logic [6:0] v, input logic [3:0] b, input logic m);
      logic [8:0] s;
      s = 9'(v) + 9'({b, 1'b0});
      if (m || v > VOL_MAX_AUDIBLE || b == BAL_MUTE || s > 9'(ATT_MUTE))
         level = ATT_MUTE; // RQ10 RQ11
      else
         level = s[7:0];
   endfunction

   assign tgt_l = level(vol_code_q, bal_q[7:4], mute_code_q[0]); // RQ12
   assign tgt_r = level(vol_code_q, bal_q[3:0], mute_code_q[1]);

   always_comb
   begin
      unique case (ramp_step_q)
         2'h0: step_len = 8'(RAMP_SAMPLES_0 - 1);
         2'h1: step_len = 8'(RAMP_SAMPLES_1 - 1);
         2'h2: step_len = 8'(RAMP_SAMPLES_2 - 1);
         2'h3: step_len = 8'(RAMP_SAMPLES_3 - 1);
      endcase
   end
   assign step = tick && step_cnt_q >= step_len;

   // mute maps to full scale; stepping 1 dB through that range reaches it in time
   function automatic logic [7:0] move(input logic [7:0] c, input logic [7:0] t);
      move = c < t ? c + 8'h01 : (c > t ? c - 8'h01 : c);
   endfunction

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         step_cnt_q <= 8'h00;
         cur_l_q <= ATT_MUTE; // RQ22
         cur_r_q <= ATT_MUTE;
         ramping_q <= 1'b0;
      end
      else
      begin
         if (tick)
            step_cnt_q <= step ? 8'h00 : step_cnt_q + 8'h01;
         if (step)
         begin
            cur_l_q <= move(cur_l_q, tgt_l); // RQ13
            cur_r_q <= move(cur_r_q, tgt_r);
         end
         ramping_q <= cur_l_q != tgt_l || cur_r_q != tgt_r; // RQ18
      end
   end
   assign reached = ramping_q && cur_l_q == tgt_l && cur_r_q == tgt_r; // RQ17

   // ----------------------------------------
   // status flags, set wins over clear
   // ----------------------------------------
   logic [2:0] set_ev;
   assign set_ev = {reached, hp_done, line_done}; // RQ15 RQ16
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
         settle_q <= 3'h0; // RQ22
      else
         settle_q <= set_ev | (settle_q & ~(wr_stat ? bus_i.wdata[2:0] : 3'h0));
   end

   // ----------------------------------------
   // outputs and read port
   // ----------------------------------------
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         power_o <= '0;
         common_pin_o <= 1'b0;
         common_pin_oe_o <= 1'b0;
         left_atten_o <= ATT_MUTE;
         right_atten_o <= ATT_MUTE;
         sample_tick_o <= 1'b0;
         irq_o <= 1'b0;
         rdata_o <= 8'h00;
      end
      else
      begin
         power_o <= '{power_ctrl_q[0], power_ctrl_q[1], power_ctrl_q[2]};
         common_pin_o <= 1'b0;
         common_pin_oe_o <= hp_set_q[BIT_COMMON_PIN]; // RQ5
         left_atten_o <= cur_l_q;
         right_atten_o <= cur_r_q;
         sample_tick_o <= tick;
         irq_o <= irq_enable_q && (|settle_q); // RQ19 RQ20 RQ21
         rdata_o <= 8'h00;
         if (bus_i.rd)
         begin
            unique case (bus_i.addr)
               OFS_OUTPUT_POWER_CONTROL: rdata_o <= {5'h00, power_ctrl_q};
               OFS_HEADPHONE_SETTINGS: rdata_o <= hp_set_q;
               OFS_OUTPUT_AMP_POWERUP_TIME: rdata_o <= line_units_q;
               OFS_CONVERTER_VOLUME: rdata_o <= {1'b0, vol_code_q};
               OFS_CONVERTER_BALANCE: rdata_o <= bal_q;
               OFS_CONVERTER_CHANNEL_MUTE: rdata_o <= {6'h00, mute_code_q};
               OFS_VOLUME_RAMP_RATE: rdata_o <= {6'h00, ramp_step_q};
               OFS_OUTPUT_SETTLE_STATUS: rdata_o <= {5'h00, settle_q};
               OFS_IRQ_STATUS: rdata_o <= {4'h0, |settle_q, 3'h0}; // RQ20
               OFS_IRQ_ENABLE: rdata_o <= {4'h0, irq_enable_q, 3'h0};
               default: rdata_o <= 8'h00;
            endcase
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_flag_set;
      !settle_q[BIT_VOL_REACHED] ##1 settle_q[BIT_VOL_REACHED];
   endsequence

   a_irq_follows_flags: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ21
      ##1 irq_o == $past(irq_enable_q && (|settle_q))) else $error("irq mismatch");
   a_reach_needs_ramp: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ18
      s_flag_set |-> $past(ramping_q)) else $error("volume flag without ramp");
   a_step_one_db: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ13
      cur_l_q != $past(cur_l_q) |-> (cur_l_q - $past(cur_l_q) == 8'h01 || $past(cur_l_q) - cur_l_q == 8'h01))
      else $error("ramp step not 1 dB");
   a_set_beats_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ17
      reached |=> settle_q[BIT_VOL_REACHED]) else $error("reached lost");
   a_hp_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ16
      hp_done |=> settle_q[BIT_HP_SETTLED]) else $error("hp flag missing");
   a_line_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ15
      line_done |=> settle_q[BIT_LINE_SETTLED]) else $error("line flag missing");
   a_line_time: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ8
      line_done |-> line_ms_q >= 12'(line_units_q) * 12'(LINE_UNIT_MS)) else $error("line early");
   a_common_drive: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ5
      ##1 common_pin_oe_o == $past(hp_set_q[BIT_COMMON_PIN])) else $error("common pin");
   a_power_map: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ1
      ##1 power_o.line_amp_enable == $past(power_ctrl_q[BIT_LINE_AMP])) else $error("power bit");

   // clear request with no competing set, and the line amp going active
   sequence s_clear_req;
      wr_stat && set_ev == 3'h0;
   endsequence
   sequence s_line_rise;
      !line_on_q ##1 line_on_q;
   endsequence

   a_power_hp: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ2
      ##1 power_o.headphone_amp_enable == $past(power_ctrl_q[BIT_HEADPHONE_AMP]))
      else $error("headphone power bit");
   a_power_conv: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ3
      ##1 power_o.converter_enable == $past(power_ctrl_q[BIT_CONVERTER]))
      else $error("converter power bit");
   a_ctrl_write: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ1
      wr_ctl |=> power_ctrl_q == $past(bus_i.wdata[2:0])) else $error("control write lost");
   a_vol_mute: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ10
      vol_code_q > VOL_MAX_AUDIBLE |-> tgt_l == ATT_MUTE && tgt_r == ATT_MUTE) else $error("volume mute");
   a_vol_level: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ10
      mute_code_q == 2'h0 && bal_q == 8'h00 && vol_code_q <= VOL_MAX_AUDIBLE |-> tgt_l == 8'(vol_code_q))
      else $error("volume level");
   a_bal_mute: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ11
      bal_q[3:0] == BAL_MUTE |-> tgt_r == ATT_MUTE) else $error("balance mute");
   a_mute_left: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ12
      mute_code_q[0] |-> tgt_l == ATT_MUTE) else $error("left mute");
   a_mute_right: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ12
      mute_code_q[1] |-> tgt_r == ATT_MUTE) else $error("right mute");
   a_step_on_tick: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ13
      cur_r_q != $past(cur_r_q) |-> $past(step)) else $error("ramp moved off a step");
   a_clear_works: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ16
      s_clear_req |=> (settle_q & $past(bus_i.wdata[2:0])) == 3'h0) else $error("status not cleared");
   a_line_once: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ15
      s_line_rise |-> settle_q[BIT_LINE_SETTLED]) else $error("line settle flag missing");
   a_irq_gated: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ21
      !irq_enable_q |=> !irq_o) else $error("interrupt not gated");
   a_ready_status: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ20
      bus_i.rd && bus_i.addr == OFS_IRQ_STATUS |=> rdata_o[BIT_OUTPUT_READY] == $past(|settle_q))
      else $error("ready status read");
endmodule

// ---- dv/aopv_host.sv ----
// host software model: register master with read-data scoreboard
`timescale 1ns/10ps
module aopv_host
   import aopv_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic [7:0] rdata_i,
   output aopv_pkg::aopv_bus_req_t bus_o
);
   logic [7:0] exp_q[$];
   logic pend_q = 1'b0;
   initial
   begin
      bus_o = '0;
   end
   // ----------------------------------------
   // bus cycles
   // ----------------------------------------
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_i);
      // idle lines never hold the last value
      bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge ref_clk_i);
      bus_o <= '{addr: a, wdata: 8'h5a, wr: 1'b0, rd: 1'b1};
      exp_q.push_back(e);
      @(posedge ref_clk_i);
      bus_o <= '{addr: ~a, wdata: 8'ha5, wr: 1'b0, rd: 1'b0};
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge ref_clk_i)
   begin
      if (pend_q)
         aopv_ctrl_bench.check("rdata", rdata_i, exp_q.pop_front());
      pend_q <= bus_o.rd;
   end
endmodule

// ---- dv/aopv_ctrl_bench.sv ----
// self-checking bench for the output power and volume control block
`timescale 1ns/10ps
module aopv_ctrl_bench;
   import aopv_pkg::*;
   localparam int DIV = 4;
   localparam int MS = 10;
   logic ref_clk_i, srst_i, cpin, coe, tick, irq;
   aopv_rate_family_t fam;
   aopv_bus_req_t bus;
   aopv_power_t pwr;
   logic [7:0] latt, ratt, rdata, v, b;
   logic [15:0] lfsr_q;
   int fail_count, samples_checked, cyc;
   int smp[4] = '{RAMP_SAMPLES_0, RAMP_SAMPLES_1, RAMP_SAMPLES_2, RAMP_SAMPLES_3};
   int hpms[3] = '{HP_TIME_44K_MS, HP_TIME_48K_MS, HP_TIME_32K_MS};

   aopv_ctrl #(.SAMPLE_DIV(DIV), .MS_CYCLES(MS)) dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .bus_i(bus), .rate_family_i(fam), .power_o(pwr), .common_pin_o(cpin), .common_pin_oe_o(coe),
      .left_atten_o(latt), .right_atten_o(ratt), .sample_tick_o(tick), .irq_o(irq), .rdata_o(rdata));
   aopv_host host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .bus_o(bus));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      if (fail_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic tick_n(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task automatic wait_irq(input int lo, input int hi);
      int n;
      n = 0;
      while (irq !== 1'b1 && n <= hi)
      begin
         @(posedge ref_clk_i);
         n++;
      end
      check("irq_delay", {7'h0, n >= lo && n <= hi}, 8'h01);
   endtask
   task automatic wait_att(input logic [7:0] l, input logic [7:0] r);
      int n;
      n = 0;
      while (!(latt === l && ratt === r) && n < 1100)
      begin
         @(posedge ref_clk_i);
         n++;
      end
      check("left_atten", latt, l);
      check("right_atten", ratt, r);
   endtask
   // sample tick period, counted edge to edge on the pulse
   task automatic tick_gap();
      int n;
      n = 0;
      while (tick !== 1'b1)
         @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      while (tick !== 1'b1 && n < 4 * DIV)
      begin
         @(posedge ref_clk_i);
         n++;
      end
      check("tick_period", 8'(n + 1), 8'(DIV));
   endtask
   // flags are sticky, so every timed wait starts from a cleared status
   task automatic clr();
      host.wr(OFS_OUTPUT_SETTLE_STATUS, 8'h07);
      tick_n(2);
      check("irq_clear", {7'h0, irq}, 8'h00);
   endtask

   initial
   begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         fail_count++;
         summarize();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      srst_i = 1'b1;
      fam = AOPV_FAM_48K;
      lfsr_q = 16'hb4fc;
      tick_n(20);
      srst_i <= 1'b0;
      check("power", {5'h0, pwr}, 8'h00);
      check("oe", {7'h0, coe}, 8'h00);
      host.rd(OFS_OUTPUT_POWER_CONTROL, 8'h00);
      host.rd(OFS_HEADPHONE_SETTINGS, RST_HEADPHONE_SETTINGS);
      host.rd(OFS_CONVERTER_VOLUME, 8'h00);
      host.rd(OFS_CONVERTER_BALANCE, 8'h00);
      host.rd(OFS_CONVERTER_CHANNEL_MUTE, 8'h03);
      host.rd(OFS_VOLUME_RAMP_RATE, 8'h01);
      host.rd(OFS_OUTPUT_SETTLE_STATUS, 8'h00);
      host.rd(OFS_IRQ_ENABLE, 8'h00);
      host.rd(12'h810, 8'h00);
      check("atten_rst", latt, 8'hff);
      tick_gap();
      host.wr(OFS_IRQ_ENABLE, 8'h08);
      tick_n(3);
      check("irq_idle", {7'h0, irq}, 8'h00);
      // converter and headphone amp are off here, so the rate may change
      host.wr(OFS_VOLUME_RAMP_RATE, 8'h03);
      host.wr(OFS_CONVERTER_CHANNEL_MUTE, 8'h00);
      wait_att(8'h00, 8'h00);
      tick_n(3);
      host.rd(OFS_OUTPUT_SETTLE_STATUS, 8'h04);
      host.rd(OFS_IRQ_STATUS, 8'h08);
      check("irq_on", {7'h0, irq}, 8'h01);
      for (int k = 0; k < 4; k++)
      begin
         clr();
         host.wr(OFS_VOLUME_RAMP_RATE, k[7:0]);
         host.wr(OFS_CONVERTER_VOLUME, k[0] ? 8'h00 : 8'h02);
         wait_irq(smp[k] * DIV, 2 * smp[k] * DIV + 8);
      end
      for (int k = 0; k < 3; k++)
      begin
         lfsr_q = lfsr_next(lfsr_q);
         v = {3'h0, lfsr_q[4:0]};
         b = {5'h0, lfsr_q[10:8]};
         host.wr(OFS_CONVERTER_VOLUME, v);
         host.wr(OFS_CONVERTER_BALANCE, {b[3:0], b[3:0]});
         wait_att(8'(v + 2 * b), 8'(v + 2 * b));
      end
      host.wr(OFS_CONVERTER_VOLUME, {1'b0, VOL_MAX_AUDIBLE});
      host.wr(OFS_CONVERTER_BALANCE, 8'hee);
      wait_att(8'h64, 8'h64);
      host.wr(OFS_CONVERTER_BALANCE, 8'hff);
      wait_att(8'hff, 8'hff);
      host.wr(OFS_CONVERTER_BALANCE, 8'h00);
      host.wr(OFS_CONVERTER_VOLUME, 8'h49);
      wait_att(8'hff, 8'hff);
      tick_n(4);
      clr();
      host.wr(OFS_CONVERTER_CHANNEL_MUTE, 8'h03);
      tick_n(60);
      host.rd(OFS_OUTPUT_SETTLE_STATUS, 8'h00);
      host.wr(OFS_CONVERTER_VOLUME, 8'h00);
      host.wr(OFS_CONVERTER_CHANNEL_MUTE, 8'h01);
      wait_att(8'hff, 8'h00);
      host.wr(OFS_CONVERTER_CHANNEL_MUTE, 8'h02);
      wait_att(8'h00, 8'hff);
      tick_n(4);
      clr();
      // line amp is off, so its power-up setting may change
      host.wr(OFS_OUTPUT_AMP_POWERUP_TIME, 8'h01);
      host.wr(OFS_OUTPUT_POWER_CONTROL, 8'h01);
      tick_n(2);
      check("power", {5'h0, pwr}, 8'h04);
      wait_irq(10 * MS - 12, 10 * MS + 6);
      host.rd(OFS_OUTPUT_SETTLE_STATUS, 8'h01);
      host.wr(OFS_OUTPUT_POWER_CONTROL, 8'h00);
      tick_n(4);
      clr();
      host.wr(OFS_HEADPHONE_SETTINGS, 8'h00);
      for (int f = 0; f < 3; f++)
      begin
         fam <= aopv_rate_family_t'(f);
         host.wr(OFS_OUTPUT_POWER_CONTROL, f[0] ? 8'h00 : 8'h02);
         wait_irq(hpms[f] * MS - 8, hpms[f] * MS + 6);
         host.rd(OFS_OUTPUT_SETTLE_STATUS, 8'h02);
         check("power", {5'h0, pwr}, f[0] ? 8'h00 : 8'h02);
         clr();
      end
      host.wr(OFS_OUTPUT_POWER_CONTROL, 8'h04);
      tick_n(2);
      check("power", {5'h0, pwr}, 8'h01);
      host.wr(OFS_OUTPUT_POWER_CONTROL, 8'h00);
      host.wr(OFS_HEADPHONE_SETTINGS, 8'h01);
      tick_n(2);
      check("oe", {7'h0, coe}, 8'h01);
      check("pin", {7'h0, cpin}, 8'h00);
      host.rd(OFS_HEADPHONE_SETTINGS, 8'h01);
      host.wr(OFS_HEADPHONE_SETTINGS, 8'h00);
      tick_n(2);
      check("oe", {7'h0, coe}, 8'h00);
      // slow ramp cut short by a reset in mid-run
      host.wr(OFS_VOLUME_RAMP_RATE, 8'h00);
      host.wr(OFS_CONVERTER_VOLUME, 8'h40);
      host.wr(OFS_OUTPUT_POWER_CONTROL, 8'h01);
      tick_n(200);
      srst_i <= 1'b1;
      tick_n(3);
      srst_i <= 1'b0;
      tick_n(1);
      check("atten_rst", latt, 8'hff);
      check("power", {5'h0, pwr}, 8'h00);
      host.rd(OFS_OUTPUT_SETTLE_STATUS, 8'h00);
      host.rd(OFS_CONVERTER_VOLUME, 8'h00);
      tick_n(3);
      summarize();
   end
endmodule
